// File: core/sops_pin_selector.sv
// Behaviour
// R1: Host presents transmit bits valid at serial clock rising edge when not inverted.
// R2: Code 0x0C drives the synchronous serial receive data.
// R3: Code 0x0D drives the asynchronous serial receive data.
// R4: Code 0x0E shows carrier sense; cleared on entering idle.
// R5: Code 0x0F shows checksum match; cleared on entering or restarting receive.
// R6: Codes 0x16 and 23 drive upper and lower decided symbol bits.
// R7: Code 0x1D drives the received symbol tick.
// R8: Code 0x1B drives transmit amplifier power-down.
// R9: Code 0x1C drives receive amplifier power-down.
// R10: Codes 0x24,0x25,0x26,0x29,0x2B: wake events, slow clock, ready-low, oscillator settled.
// R11: Codes below 0x20 held fixed in sleep until ready-low falls.
// R12: Host trusts pin 1 only while chip select is high.
// R13: Code 0x2F drives constant low, or high when inverted.
`timescale 1ns/100ps
module sops_pin_selector #(
  parameter int ADDR_W = 8,
  parameter int PINS   = 3
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              syncRxData,
  input  wire logic              asyncRxData,
  input  wire logic              rssiAboveThreshold,
  input  wire logic              enterIdle,
  input  wire logic              crcMatch,
  input  wire logic              rxEnter,
  input  wire logic [1:0]        rxDecidedSymbolBit,
  input  wire logic              rxSymbolTick,
  input  wire logic              txAmpPowerdown,
  input  wire logic              rxAmpPowerdown,
  input  wire logic              wakeTimerEventA,
  input  wire logic              wakeTimerEventB,
  input  wire logic              chipReadyLow,
  input  wire logic              oscillatorSettled,
  input  wire logic              sleepState,
  output logic [PINS-1:0]        generalOutputPin,
  output logic [PINS-1:0]        generalOutputPinOe,
  output logic                   irq
);

  // ----------------------------------------------------------------
  // Radio-side state
  // ----------------------------------------------------------------
  localparam int EVT_W = sops_pkg::EVT_N;

  logic             carrierQ;
  logic             crcOkQ;
  logic             holdQ;
  logic             slowClk;
  logic [6:0]       selQ [PINS];
  logic [EVT_W-1:0] statusQ;
  logic [EVT_W-1:0] enableQ;
  logic [EVT_W-1:0] evtRaise;
  logic [63:0]      srcBus;
  logic             irqQ;

  // Carrier follows the threshold compare but drops on idle entry.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      carrierQ <= 1'h0;
    end else begin
      carrierQ <= rssiAboveThreshold & ~enterIdle; // R4
    end
  end

  // Checksum match is sticky; a match in the restart cycle still sets it.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      crcOkQ <= 1'h0;
    end else if (crcMatch) begin
      crcOkQ <= 1'h1;
    end else if (rxEnter) begin
      crcOkQ <= 1'h0; // R5
    end
  end

  // Sleep hold starts in sleep and ends once ready-low falls.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      holdQ <= 1'h0;
    end else if (sleepState && chipReadyLow) begin
      holdQ <= 1'h1; // R11
    end else if (!chipReadyLow) begin
      holdQ <= 1'h0; // R11
    end
  end

  sops_slow_clock #(
    .DIV (sops_pkg::SLOW_CLK_DIV)
  ) u_slow (
    .core_clk (core_clk),
    .rst      (rst),
    .slowClk  (slowClk)
  );

  // ----------------------------------------------------------------
  // Source table indexed by selection code
  // ----------------------------------------------------------------
  // Unlisted codes, reserved ones and the fixed code read as zero.
  always_comb begin
    srcBus                                  = '0;
    srcBus[sops_pkg::CODE_SYNC_DATA]        = syncRxData; // R2
    srcBus[sops_pkg::CODE_ASYNC_DATA]       = asyncRxData; // R3
    srcBus[sops_pkg::CODE_CARRIER]          = carrierQ; // R4
    srcBus[sops_pkg::CODE_CRC_OK]           = crcOkQ; // R5
    srcBus[sops_pkg::CODE_DECIDED_HI]       = rxDecidedSymbolBit[1]; // R6
    srcBus[sops_pkg::CODE_DECIDED_LO]       = rxDecidedSymbolBit[0]; // R6
    srcBus[sops_pkg::CODE_TX_AMP_PD]        = txAmpPowerdown; // R8
    srcBus[sops_pkg::CODE_RX_AMP_PD]        = rxAmpPowerdown; // R9
    srcBus[sops_pkg::CODE_SYMBOL_TICK]      = rxSymbolTick; // R7
    srcBus[sops_pkg::CODE_WAKE_A]           = wakeTimerEventA; // R10
    srcBus[sops_pkg::CODE_WAKE_B]           = wakeTimerEventB; // R10
    srcBus[sops_pkg::CODE_SLOW_CLK]         = slowClk; // R10
    srcBus[sops_pkg::CODE_CHIP_READY_LOW]   = chipReadyLow; // R10
    srcBus[sops_pkg::CODE_OSC_SETTLED]      = oscillatorSettled; // R10
    srcBus[sops_pkg::CODE_FIXED]            = 1'h0; // R13
  end

  // Pin 1 shares the serial data output and idles high, or low when inverted, in the sleep hold.
  for (genvar p = 0; p < PINS; p++) begin : g_pin
    sops_pin_slice #(
      .HOLD_HIGH ((p == 1) ? 1'h1 : 1'h0)
    ) u_slice (
      .core_clk (core_clk),
      .rst      (rst),
      .selCode  (selQ[p][5:0]),
      .invert   (selQ[p][sops_pkg::SEL_INV_BIT]),
      .hold     (holdQ),
      .srcBus   (srcBus),
      .pinOut   (generalOutputPin[p]),
      .pinOe    (generalOutputPinOe[p])
    );
  end

  // ----------------------------------------------------------------
  // Bus slave: write path
  // ----------------------------------------------------------------
  logic              awHeldQ;
  logic              wHeldQ;
  logic [ADDR_W-1:0] awAddrQ;
  logic [31:0]       wDataQ;
  logic              wLaneQ;
  logic              doWrite;
  logic              writeHit;

  assign doWrite = awHeldQ && wHeldQ && !s_axi_bvalid;

  // Address and data are caught independently and held until the write.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'h0;
      awHeldQ       <= 1'h0;
      awAddrQ       <= '0;
    end else if (s_axi_awready && s_axi_awvalid) begin
      s_axi_awready <= 1'h0;
      awHeldQ       <= 1'h1;
      awAddrQ       <= {s_axi_awaddr[ADDR_W-1:2], 2'h0};
    end else begin
      if (doWrite) begin
        awHeldQ <= 1'h0;
      end
      s_axi_awready <= !awHeldQ && !s_axi_bvalid;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_wready <= 1'h0;
      wHeldQ       <= 1'h0;
      wDataQ       <= '0;
      wLaneQ       <= 1'h0;
    end else if (s_axi_wready && s_axi_wvalid) begin
      s_axi_wready <= 1'h0;
      wHeldQ       <= 1'h1;
      wDataQ       <= s_axi_wdata;
      wLaneQ       <= s_axi_wstrb[0];
    end else begin
      if (doWrite) begin
        wHeldQ <= 1'h0;
      end
      s_axi_wready <= !wHeldQ && !s_axi_bvalid;
    end
  end

  // Decode of every mapped word; status and pin state take writes without effect.
  always_comb begin
    writeHit = (awAddrQ == sops_pkg::OFS_STATUS) || (awAddrQ == sops_pkg::OFS_INT_CLEAR)
            || (awAddrQ == sops_pkg::OFS_INT_ENABLE) || (awAddrQ == sops_pkg::OFS_PIN_STATE);
    for (int i = 0; i < PINS; i++) begin
      writeHit = writeHit || (awAddrQ == sops_pkg::OFS_SELECT0 + 8'(i) * sops_pkg::OFS_STEP);
    end
  end

  // The response follows the write by one cycle.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'h0;
      s_axi_bresp  <= sops_pkg::RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'h1;
      s_axi_bresp  <= writeHit ? sops_pkg::RESP_OKAY : sops_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'h0;
    end
  end

  // Select registers: code in the low six bits, polarity above.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      selQ[0] <= sops_pkg::SEL0_RST;
      selQ[1] <= sops_pkg::SEL1_RST;
      selQ[2] <= sops_pkg::SEL2_RST;
    end else if (doWrite && wLaneQ) begin
      for (int i = 0; i < PINS; i++) begin
        if (awAddrQ == sops_pkg::OFS_SELECT0 + 8'(i) * sops_pkg::OFS_STEP) begin
          selQ[i] <= wDataQ[6:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, enable and clear
  // ----------------------------------------------------------------
  assign evtRaise = {wakeTimerEventB, wakeTimerEventA, crcMatch, rssiAboveThreshold & ~carrierQ};

  // Raising events win over a clear in the same cycle.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      statusQ <= '0;
    end else if (doWrite && wLaneQ && awAddrQ == sops_pkg::OFS_INT_CLEAR) begin
      statusQ <= (statusQ & ~wDataQ[EVT_W-1:0]) | evtRaise;
    end else begin
      statusQ <= statusQ | evtRaise;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      enableQ <= '0;
    end else if (doWrite && wLaneQ && awAddrQ == sops_pkg::OFS_INT_ENABLE) begin
      enableQ <= wDataQ[EVT_W-1:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irqQ <= 1'h0;
    end else begin
      irqQ <= |(statusQ & enableQ);
    end
  end

  assign irq = irqQ;

  // ----------------------------------------------------------------
  // Bus slave: read path
  // ----------------------------------------------------------------
  logic [31:0] readWord;
  logic        readHit;

  // Read mux; the clear register reads as zero.
  always_comb begin
    readWord = '0;
    readHit  = 1'h1;
    if (s_axi_araddr[ADDR_W-1:2] == sops_pkg::OFS_STATUS[ADDR_W-1:2]) begin
      readWord[EVT_W-1:0] = statusQ;
    end else if (s_axi_araddr[ADDR_W-1:2] == sops_pkg::OFS_INT_ENABLE[ADDR_W-1:2]) begin
      readWord[EVT_W-1:0] = enableQ;
    end else if (s_axi_araddr[ADDR_W-1:2] == sops_pkg::OFS_INT_CLEAR[ADDR_W-1:2]) begin
      readWord = '0;
    end else if (s_axi_araddr[ADDR_W-1:2] == sops_pkg::OFS_PIN_STATE[ADDR_W-1:2]) begin
      readWord[6:0] = {holdQ, generalOutputPinOe, generalOutputPin};
    end else if (s_axi_araddr[ADDR_W-1:2] < 6'(PINS)) begin
      readWord[6:0] = selQ[s_axi_araddr[3:2]];
    end else begin
      readHit = 1'h0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'h0;
      s_axi_rvalid  <= 1'h0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= sops_pkg::RESP_OKAY;
    end else if (s_axi_arready && s_axi_arvalid) begin
      s_axi_arready <= 1'h0;
      s_axi_rvalid  <= 1'h1;
      s_axi_rdata   <= readWord;
      s_axi_rresp   <= readHit ? sops_pkg::RESP_OKAY : sops_pkg::RESP_SLVERR;
    end else begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'h0;
      end
      s_axi_arready <= !s_axi_rvalid;
    end
  end

  // ----------------------------------------------------------------
  // Assertions on pin 0, pin 1 and pin 2 paths
  // ----------------------------------------------------------------
  logic [5:0] code0;
  logic       inv0;
  logic       live0;
  assign code0 = selQ[0][5:0];
  assign inv0  = selQ[0][sops_pkg::SEL_INV_BIT];
  assign live0 = !holdQ || (code0 >= sops_pkg::CODE_SLEEP_LIVE);

  property p_sync_data;
    @(posedge core_clk) disable iff (rst)
    (code0 == sops_pkg::CODE_SYNC_DATA && live0) |=>
      generalOutputPin[0] == ($past(syncRxData) ^ $past(inv0));
  endproperty
  a_sync_data: assert property (p_sync_data) else $error("Sync data not routed."); // R2

  property p_async_data;
    @(posedge core_clk) disable iff (rst)
    (code0 == sops_pkg::CODE_ASYNC_DATA && live0 && !inv0) |=>
      generalOutputPin[0] == $past(asyncRxData);
  endproperty
  a_async_data: assert property (p_async_data) else $error("Async data not routed."); // R3

  property p_carrier_idle;
    @(posedge core_clk) disable iff (rst)
    enterIdle ##1 (code0 == sops_pkg::CODE_CARRIER && live0 && !inv0) |=> !generalOutputPin[0];
  endproperty
  a_carrier_idle: assert property (p_carrier_idle) else $error("Carrier kept in idle."); // R4

  property p_crc_restart;
    @(posedge core_clk) disable iff (rst)
    (rxEnter && !crcMatch) |=> !crcOkQ ##1 (crcOkQ == $past(crcMatch));
  endproperty
  a_crc_restart: assert property (p_crc_restart) else $error("Checksum flag not cleared."); // R5

  property p_decided_hi;
    @(posedge core_clk) disable iff (rst)
    (code0 == sops_pkg::CODE_DECIDED_HI && live0) |=>
      generalOutputPin[0] == ($past(rxDecidedSymbolBit[1]) ^ $past(inv0));
  endproperty
  a_decided_hi: assert property (p_decided_hi) else $error("Decided bit not routed."); // R6

  property p_tick;
    @(posedge core_clk) disable iff (rst)
    (code0 == sops_pkg::CODE_SYMBOL_TICK && live0 && rxSymbolTick && !inv0) |=>
      generalOutputPin[0];
  endproperty
  a_tick: assert property (p_tick) else $error("Symbol tick lost."); // R7

  property p_amp_pd;
    @(posedge core_clk) disable iff (rst)
    (code0 == sops_pkg::CODE_TX_AMP_PD && live0) |=>
      generalOutputPin[0] == ($past(txAmpPowerdown) ^ $past(inv0));
  endproperty
  a_amp_pd: assert property (p_amp_pd) else $error("Amplifier control not routed."); // R8

  property p_wake_a;
    @(posedge core_clk) disable iff (rst)
    (code0 == sops_pkg::CODE_WAKE_A) |=>
      generalOutputPin[0] == ($past(wakeTimerEventA) ^ $past(inv0));
  endproperty
  a_wake_a: assert property (p_wake_a) else $error("Wake event not routed."); // R10

  property p_sleep_hold;
    @(posedge core_clk) disable iff (rst)
    (holdQ && selQ[1][5:0] < sops_pkg::CODE_SLEEP_LIVE) |=>
      generalOutputPin[1] == !$past(selQ[1][sops_pkg::SEL_INV_BIT]);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("Sleep hold level wrong."); // R11

  property p_fixed;
    @(posedge core_clk) disable iff (rst)
    (selQ[2][5:0] == sops_pkg::CODE_FIXED) |=>
      generalOutputPin[2] == $past(selQ[2][sops_pkg::SEL_INV_BIT]) && generalOutputPinOe[2];
  endproperty
  a_fixed: assert property (p_fixed) else $error("Fixed level wrong."); // R13

  c_tick_route: cover property (@(posedge core_clk) disable iff (rst)
    code0 == sops_pkg::CODE_SYMBOL_TICK && rxSymbolTick);
  c_hold_release: cover property (@(posedge core_clk) disable iff (rst)
    holdQ ##1 !holdQ);
  c_irq: cover property (@(posedge core_clk) disable iff (rst) $rose(irq));

endmodule

// File: core/sops_pin_slice.sv
`timescale 1ns/100ps
module sops_pin_slice #(
  parameter logic HOLD_HIGH = 1'h0
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [5:0]  selCode,
  input  wire logic        invert,
  input  wire logic        hold,
  input  wire logic [63:0] srcBus,
  output logic             pinOut,
  output logic             pinOe
);

  logic pinOutQ;
  logic pinOeQ;

  // Register the selected source, polarity applied; sleep hold wins for low codes.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pinOutQ <= 1'h0;
      pinOeQ  <= 1'h0;
    end else begin
      pinOeQ <= (selCode != sops_pkg::CODE_HIGH_Z);
      if (hold && (selCode < sops_pkg::CODE_SLEEP_LIVE)) begin // R11
        pinOutQ <= HOLD_HIGH ^ invert;
      end else begin
        pinOutQ <= srcBus[selCode] ^ invert;
      end
    end
  end

  assign pinOut = pinOutQ;
  assign pinOe  = pinOeQ;

endmodule

// File: core/sops_pkg.sv
package sops_pkg;

  // ----------------------------------------------------------------
  // Selection codes
  // ----------------------------------------------------------------
  localparam logic [5:0] CODE_SYNC_DATA      = 6'h0C;
  localparam logic [5:0] CODE_ASYNC_DATA     = 6'h0D;
  localparam logic [5:0] CODE_CARRIER        = 6'h0E;
  localparam logic [5:0] CODE_CRC_OK         = 6'h0F;
  localparam logic [5:0] CODE_DECIDED_HI     = 6'h16;
  localparam logic [5:0] CODE_DECIDED_LO     = 6'h17;
  localparam logic [5:0] CODE_TX_AMP_PD      = 6'h1B;
  localparam logic [5:0] CODE_RX_AMP_PD      = 6'h1C;
  localparam logic [5:0] CODE_SYMBOL_TICK    = 6'h1D;
  localparam logic [5:0] CODE_SLEEP_LIVE     = 6'h20;
  localparam logic [5:0] CODE_WAKE_A         = 6'h24;
  localparam logic [5:0] CODE_WAKE_B         = 6'h25;
  localparam logic [5:0] CODE_SLOW_CLK       = 6'h26;
  localparam logic [5:0] CODE_CHIP_READY_LOW = 6'h29;
  localparam logic [5:0] CODE_OSC_SETTLED    = 6'h2B;
  localparam logic [5:0] CODE_HIGH_Z         = 6'h2E;
  localparam logic [5:0] CODE_FIXED          = 6'h2F;

  // ----------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_SELECT0    = 8'h00;
  localparam logic [7:0] OFS_STATUS     = 8'h0C;
  localparam logic [7:0] OFS_INT_CLEAR  = 8'h10;
  localparam logic [7:0] OFS_INT_ENABLE = 8'h14;
  localparam logic [7:0] OFS_PIN_STATE  = 8'h18;
  localparam logic [7:0] OFS_STEP       = 8'h04;

  // Select register layout and reset values.
  localparam int         SEL_INV_BIT = 6;
  localparam logic [6:0] SEL0_RST    = 7'h26;
  localparam logic [6:0] SEL1_RST    = 7'h2E;
  localparam logic [6:0] SEL2_RST    = 7'h29;

  // Event bit positions in status, clear and enable.
  localparam int EVT_CARRIER = 0;
  localparam int EVT_CRC_OK  = 1;
  localparam int EVT_WAKE_A  = 2;
  localparam int EVT_WAKE_B  = 3;
  localparam int EVT_N       = 4;

  // Slow clock period in core clock cycles.
  localparam int SLOW_CLK_DIV = 256;

  // Bus answers.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: core/sops_slow_clock.sv
`timescale 1ns/100ps
module sops_slow_clock #(
  parameter int DIV = sops_pkg::SLOW_CLK_DIV
) (
  input  wire logic core_clk,
  input  wire logic rst,
  output logic      slowClk
);

  localparam int HALF = DIV / 2;
  localparam int CW   = $clog2(HALF);

  logic [CW-1:0] countQ;
  logic          slowQ;

  // Toggle every half period so the output has even duty.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      countQ <= '0;
      slowQ  <= 1'h0;
    end else if (countQ == CW'(HALF - 1)) begin
      countQ <= '0;
      slowQ  <= ~slowQ;
    end else begin
      countQ <= countQ + CW'(1);
    end
  end

  assign slowClk = slowQ;

endmodule

// File: testbench/sops_host_monitor.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Host side monitor of the three output pins
// ----------------------------------------------------------------
module sops_host_monitor (
  input  wire logic       core_clk,
  input  wire logic [2:0] pinLevel,
  input  wire logic [2:0] pinOe,
  input  wire logic       csHigh,
  output logic [2:0]      hostSeen,
  output logic            pin1Valid
);
  logic [2:0] lastDriven;

  // A released pin floats, so the host sees the inverse of the last driven level.
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 3; i++) begin
      if (pinOe[i]) begin
        lastDriven[i] <= pinLevel[i];
        hostSeen[i]   <= pinLevel[i];
      end else begin
        hostSeen[i] <= ~lastDriven[i];
      end
    end
  end
  // The shared second pin is trusted only while chip select is high.
  assign pin1Valid = csHigh & pinOe[1];
endmodule

// File: testbench/test_status_output_pin_selector.sv
`timescale 1ns/100ps
module test_status_output_pin_selector;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        core_clk = 1'h0;
  logic        rst      = 1'h1;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [11:0] src;
  logic [2:0]  pins, oe, hostSeen;
  logic [65:0] note;
  logic [65:0] expQ[$];
  logic        awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic        arready, rvalid, irq, rssi, idle, crc, rxEnt, sleep, csHigh, pin1Valid, inv;
  int          err_count = 0;
  int          checked   = 0;
  int          n;
  localparam logic [5:0] CODES[12] = '{6'h0C, 6'h0D, 6'h17, 6'h16, 6'h1D, 6'h1B,
                                       6'h1C, 6'h24, 6'h25, 6'h29, 6'h2B, 6'h2F};

  sops_pin_selector u_sops_pin_selector (
    .core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .syncRxData(src[0]), .asyncRxData(src[1]), .rssiAboveThreshold(rssi),
    .enterIdle(idle), .crcMatch(crc), .rxEnter(rxEnt), .rxDecidedSymbolBit(src[3:2]),
    .rxSymbolTick(src[4]), .txAmpPowerdown(src[5]), .rxAmpPowerdown(src[6]),
    .wakeTimerEventA(src[7]), .wakeTimerEventB(src[8]), .chipReadyLow(src[9]),
    .oscillatorSettled(src[10]), .sleepState(sleep), .generalOutputPin(pins),
    .generalOutputPinOe(oe), .irq(irq)
  );

  sops_host_monitor u_sops_host_monitor (
    .core_clk(core_clk), .pinLevel(pins), .pinOe(oe), .csHigh(csHigh),
    .hostSeen(hostSeen), .pin1Valid(pin1Valid)
  );

  // Free running core clock.
  initial begin
    forever #25 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task stop_test;
    $display("checks %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task waitClk(input int c);
    repeat (c) @(posedge core_clk);
  endtask

  // Write one word and compare the response code.
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    bit awDone, wDone;
    int k;
    awDone = 0;
    wDone = 0;
    k = 0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge core_clk);
      k++;
      if (awready && !awDone) begin
        awDone = 1;
        awvalid <= 1'h0;
      end
      if (wready && !wDone) begin
        wDone = 1;
        wvalid <= 1'h0;
      end
    end while (!bvalid && k < 200);
    bready <= 1'h0;
    if (k >= 200) begin
      err_count++;
      stop_test();
    end
    check("bresp", {30'h0, bresp}, {30'h0, resp});
  endtask

  // Read one word; the expectation goes to the queue first.
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] r);
    bit arDone;
    int k;
    arDone = 0;
    k = 0;
    expQ.push_back({r, m, e});
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge core_clk);
      k++;
      if (arready && !arDone) begin
        arDone = 1;
        arvalid <= 1'h0;
      end
    end while (!rvalid && k < 200);
    rready <= 1'h0;
    if (k >= 200) begin
      err_count++;
      stop_test();
    end
  endtask

  // Counts core clock edges up to the next rising level seen by the host.
  task rise(output int c);
    logic p;
    c = 0;
    p = 1'h1;
    do begin
      @(posedge core_clk);
      c++;
      if (!p && hostSeen[0]) break;
      p = hostSeen[0];
    end while (c < 600);
    if (c >= 600) begin
      err_count++;
      stop_test();
    end
  endtask

  // Compares every read answer with the oldest queued expectation.
  always @(posedge core_clk) begin
    if (rvalid && rready) begin
      if (expQ.size() == 0) begin
        check("read count", 32'h1, 32'h0);
      end else begin
        note = expQ.pop_front();
        check("rdata", rdata & note[63:32], note[31:0] & note[63:32]);
        check("rresp", {30'h0, rresp}, {30'h0, note[65:64]});
      end
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, rssi, idle, crc, rxEnt, sleep} = 10'h0;
    {awaddr, araddr, wdata, wstrb, src, csHigh} = {16'h0, 32'h0, 4'hF, 12'h0, 1'h1};
    void'($urandom(44));
    waitClk(10);
    rst <= 1'h0;
    waitClk(2);
    rd(8'h00, 32'h26, 32'hFFFFFFFF, 2'h0);
    rd(8'h04, 32'h2E, 32'hFFFFFFFF, 2'h0);
    rd(8'h08, 32'h29, 32'hFFFFFFFF, 2'h0);
    rd(8'h14, 32'h0, 32'hFFFFFFFF, 2'h0);
    rd(8'h1C, 32'h0, 32'hFFFFFFFF, 2'h2);
    wr(8'h1C, 32'h1, 2'h2);
    // Every listed code, both polarities, random source levels.
    for (int i = 0; i < 12; i++) begin
      for (int k = 0; k < 4; k++) begin
        inv = k[0];
        wr(8'h00, {25'h0, inv, CODES[i]}, 2'h0);
        src <= 12'($urandom) & 12'h7FF;
        waitClk(3);
        check("pin0 host", {31'h0, hostSeen[0]}, {31'h0, src[i] ^ inv});
        check("pin oe", {29'h0, oe}, 32'h5);
        rd(8'h18, {26'h0, 3'h5, src[9], 1'h0, src[i] ^ inv}, 32'h7D, 2'h0);
      end
    end
    src <= 12'h0;
    wr(8'h10, 32'hF, 2'h0);
    wr(8'h00, 32'h0E, 2'h0);
    wr(8'h04, 32'h0F, 2'h0);
    wr(8'h14, 32'h3, 2'h0);
    rssi <= 1'h1;
    waitClk(4);
    check("irq", {31'h0, irq}, 32'h1);
    rd(8'h0C, 32'h1, 32'hF, 2'h0);
    rd(8'h18, 32'h1, 32'h1, 2'h0);
    idle <= 1'h1;
    waitClk(3);
    rd(8'h18, 32'h0, 32'h1, 2'h0);
    idle <= 1'h0;
    rssi <= 1'h0;
    wr(8'h10, 32'h1, 2'h0);
    waitClk(2);
    check("irq", {31'h0, irq}, 32'h0);
    crc <= 1'h1;
    @(posedge core_clk);
    crc <= 1'h0;
    waitClk(3);
    rd(8'h18, 32'h2, 32'h2, 2'h0);
    wr(8'h14, 32'h0, 2'h0);
    waitClk(2);
    check("irq", {31'h0, irq}, 32'h0);
    wr(8'h14, 32'h2, 2'h0);
    waitClk(2);
    check("irq", {31'h0, irq}, 32'h1);
    rxEnt <= 1'h1;
    @(posedge core_clk);
    rxEnt <= 1'h0;
    waitClk(3);
    rd(8'h18, 32'h0, 32'h2, 2'h0);
    wr(8'h0C, 32'hFFFF, 2'h0);
    wstrb <= 4'h0;
    wr(8'h00, 32'h2F, 2'h0);
    wstrb <= 4'hF;
    rd(8'h00, 32'h0E, 32'h7F, 2'h0);
    // Sleep holds low codes until ready-low falls.
    wr(8'h00, 32'h0C, 2'h0);
    wr(8'h04, 32'h0D, 2'h0);
    src <= 12'h203;
    sleep <= 1'h1;
    waitClk(4);
    rd(8'h18, 32'h7E, 32'h7F, 2'h0);
    check("host pin1", {31'h0, hostSeen[1] & pin1Valid}, 32'h1);
    csHigh <= 1'h0;
    @(posedge core_clk);
    check("pin1 valid", {31'h0, pin1Valid}, 32'h0);
    csHigh <= 1'h1;
    wr(8'h00, 32'h24, 2'h0);
    src[7] <= 1'h1;
    waitClk(3);
    rd(8'h18, 32'h1, 32'h1, 2'h0);
    wr(8'h00, 32'h4C, 2'h0);
    waitClk(3);
    rd(8'h18, 32'h1, 32'h1, 2'h0);
    src[9] <= 1'h0;
    waitClk(4);
    rd(8'h18, 32'h3A, 32'h7F, 2'h0);
    sleep <= 1'h0;
    wr(8'h00, 32'h26, 2'h0);
    rise(n);
    rise(n);
    check("slow period", 32'(n), 32'(sops_pkg::SLOW_CLK_DIV));
    waitClk(4);
    stop_test();
  end
endmodule
